//--- rtl/hdt_clkgen.sv
// clock-pattern generator: walks a 64-step pattern, one enable per rising link-clock edge whose pattern bit is set
`timescale 1ns/1ps
`default_nettype none
module hdt_clkgen #(
  parameter int LEN = 64
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        enable,
  input  wire logic        ext_rise,
  input  wire logic        use_alt,
  input  wire logic [31:0] ptn_word0,
  input  wire logic [31:0] ptn_alt_word0,
  output logic             pat_level,
  output logic             pix_en
);
  typedef struct packed {
    logic [6:0] step;
    logic       lvl;
    logic       en;
  } hdt_cg_s;
  hdt_cg_s st_ff, nxt_st;
  logic [63:0] ptn;
  logic        bit_now;

  always_comb begin
    // only word 0 is programmable here; upper words stay zero
    ptn     = use_alt ? {32'h0000_0000, ptn_alt_word0} : {32'h0000_0000, ptn_word0};
    bit_now = ptn[st_ff.step[5:0]];
    nxt_st  = st_ff;
    nxt_st.en = 1'b0;
    if (!enable) begin
      nxt_st = '0;
    end else if (ext_rise) begin
      // pattern 1 with length 1 reproduces the input clock one-for-one
      nxt_st.lvl = 1'b1;
      nxt_st.en  = bit_now;
      nxt_st.step = (st_ff.step == 7'(LEN - 1) || ptn[63:1] == '0) ? 7'd0 :
                    st_ff.step + 7'd1;
    end else begin
      nxt_st.lvl = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pat_level = st_ff.lvl;
  assign pix_en    = st_ff.en;
endmodule // hdt_clkgen
`default_nettype wire

//--- rtl/hdt_fifo.sv
// small pixel fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module hdt_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0]      wr;
    logic [AW:0]      rd;
    logic [WIDTH-1:0] dout;
    logic             ready;
  } hdt_fifo_s;
  hdt_fifo_s st_ff, nxt_st;
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0]      cnt;
  logic             do_wr;
  logic             do_rd;

  always_comb begin
    cnt       = st_ff.wr - st_ff.rd;
    // ready is registered so that the fill-side pin comes straight from a flop
    in_ready  = st_ff.ready;
    out_valid = (cnt != '0);
    do_wr     = in_valid && in_ready;
    do_rd     = out_valid && out_ready;
    out_data  = mem_ff[st_ff.rd[AW-1:0]];
    nxt_st    = st_ff;
    if (do_wr) begin
      nxt_st.wr = st_ff.wr + 1'b1;
    end
    if (do_rd) begin
      nxt_st.rd = st_ff.rd + 1'b1;
    end
    nxt_st.dout = out_data;
    nxt_st.ready = ((nxt_st.wr - nxt_st.rd) != DEPTH[AW:0]);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // storage has no reset: contents are only read once written
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem_ff[st_ff.wr[AW-1:0]] <= in_data;
    end
  end
endmodule // hdt_fifo
`default_nettype wire

//--- rtl/hdt_map.svh
// timing, window and control constants for the 720-line display timing generator
`ifndef HDT_MAP_SVH
`define HDT_MAP_SVH
`define HDT_LINE_PERIOD_M1   11'd1649
`define HDT_FRAME_PERIOD_M1  10'd749
`define HDT_H_ACTIVE_START   11'd300
`define HDT_H_ACTIVE_LENGTH  11'd1280
`define HDT_H_BLANK_AFTER    11'd70
`define HDT_V_ACTIVE_START   10'd26
`define HDT_V_ACTIVE_LENGTH  10'd720
`define HDT_HSYNC_WIDTH      11'h050
`define HDT_BASE_X           11'h050
`define HDT_BASE_Y           10'h005
`define HDT_WIN_X_OFFSET     11'd220
`define HDT_WIN_Y_OFFSET     10'd25
`define HDT_DIGOUT_ON        8'h01
`define HDT_VSS_CLK_EXT      8'h0a
`define HDT_PTN_WORD0        32'h0000_0001
`define HDT_PTN_ALT_WORD0    32'h0000_0002
`define HDT_PTN_ALT_HSTART   16'h0001
`define HDT_PTN_LEN          7'd64
`define HDT_PTN_LEN_BITS     7
`endif

//--- rtl/hdt_pkg.sv
// types shared by the display timing generator files
package hdt_pkg;
  typedef struct packed {
    logic [10:0] x_offset;
    logic [9:0]  y_offset;
    logic [10:0] width;
    logic [9:0]  height;
  } hdt_win_s;

  typedef struct packed {
    logic        video_encoder_core_on;
    logic        nonstd_timing;
    logic        timing_master;
    logic        hd_mode;
    logic        progressive;
  } hdt_mode_s;

  typedef struct packed {
    logic        hsync;
    logic        vsync;
    logic        active;
    logic [3:0]  win_hit;
  } hdt_timing_s;

  typedef logic [15:0] hdt_pix_t;
endpackage

//--- rtl/hdt_timing.sv
// What this block does
// - each line is 1650 pixel clocks, 1280 of them active
// - blanking split 300 before active and 70 after
// - lines 0 to 25 are vertical blanking at frame top
// - 720 active lines of 1280 active pixels each
// - line and frame period settings hold 1649 and 749
// - active starts at pixel 300, line 26; sync delays zero, alternate start 1
// - horizontal sync pulse is 80 pixels wide, equal to base origin
// - window position is offset plus base origin of 80 pixels, 5 lines
// - four windows: two video, two overlay; video window 1 is forced off
// - horizontal and vertical syncs driven toward the encoder
// - pixel clock is the 74.25 MHz external clock, not internal 27 MHz
// - pattern generator up to 64 steps; here reproduces the input clock
// - pattern clock goes out on the pixel clock pin
// - field id pin disabled, display output-enable pin enabled
// - only video window 0 active, video window 1 off
// - overlay field inversion cleared when video window 0 is used
// - digital output control 0x1 enables the parallel video output
// - subsystem clock control 0x0a selects external clock, enables encoder clock
// - encoder mode: on, non-standard, master, high definition, progressive
`timescale 1ns/1ps
`default_nettype none
`include "hdt_map.svh"
module hdt_timing
  import hdt_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic                 CLK,
  input  wire logic                 RST_N,
  input  wire logic                 EXTERNAL_PIXEL_CLOCK_IN,
  input  wire logic                 TIMING_ENABLE,
  input  wire logic [7:0]           VIDEO_SUBSYSTEM_CLOCK_CONTROL,
  input  wire logic [7:0]           DIGITAL_OUTPUT_CONTROL,
  input  wire logic                 SYNC_OUTPUTS_ON,
  input  wire hdt_pkg::hdt_mode_s   ENCODER_MODE,
  input  wire logic [1:0]           VIDEO_WINDOW_MODE,
  input  wire logic [1:0]           OVERLAY_WINDOW_ON,
  input  wire logic                 OVERLAY_FIELD_INVERT,
  input  wire hdt_pkg::hdt_win_s    WIN_CFG [4],
  input  wire hdt_pkg::hdt_pix_t    PIX_DATA,
  input  wire logic                 PIX_VALID,
  output logic                      PIX_READY,
  output logic                      PIXEL_CLOCK_OUT,
  output logic                      HSYNC,
  output logic                      VSYNC,
  output logic                      DISPLAY_OE,
  output logic                      FIELD_ID,
  output logic                      FIELD_ID_PIN_ENABLE,
  output logic                      DISPLAY_OE_PIN_ENABLE,
  output hdt_pkg::hdt_pix_t         VIDEO_OUT,
  output logic [3:0]                WIN_HIT,
  output logic                      UNDERRUN,
  output logic                      CONFIG_OK
);
  import hdt_pkg::*;

  typedef struct packed {
    logic        ext_s1;
    logic        ext_s2;
    logic        ext_d;
    logic        in_rdy;
    logic [10:0] hcnt;
    logic [9:0]  vcnt;
    logic        hsync;
    logic        vsync;
    logic        oe;
    logic [3:0]  hit;
    logic [15:0] video;
    logic        underrun;
    logic        cfg_ok;
    logic        pclk;
  } hdt_top_s;

  hdt_top_s    st_ff, nxt_st;
  logic        ext_rise;
  logic        clk_sel_ext;
  logic        enc_clk_on;
  logic        pat_level;
  logic        pix_en;
  logic        enc_ready;
  logic        h_act;
  logic        v_act;
  logic [3:0]  win_on;
  logic [3:0]  hit_now;
  hdt_pix_t    fifo_data;
  logic        fifo_valid;
  logic        fifo_pop;
  logic        cfg_ok;

  // the external clock is sampled by CLK; two flops before any edge detection
  always_comb begin
    ext_rise    = st_ff.ext_s2 && !st_ff.ext_d;
    clk_sel_ext = (VIDEO_SUBSYSTEM_CLOCK_CONTROL == `HDT_VSS_CLK_EXT);
    enc_clk_on  = clk_sel_ext && ENCODER_MODE.video_encoder_core_on;
  end

  hdt_clkgen #(
    .LEN (64)
  ) u_clkgen (
    .clk           (CLK),
    .rst_n         (RST_N),
    .enable        (enc_clk_on),
    .ext_rise      (ext_rise),
    .use_alt       (1'b0),
    .ptn_word0     (`HDT_PTN_WORD0),
    .ptn_alt_word0 (`HDT_PTN_ALT_WORD0),
    .pat_level     (pat_level),
    .pix_en        (pix_en)
  );

  hdt_fifo #(
    .WIDTH ($bits(hdt_pix_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK),
    .rst_n     (RST_N),
    .in_data   (PIX_DATA),
    .in_valid  (PIX_VALID),
    .in_ready  (PIX_READY),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // encoder mode must select the full hd progressive master combination
  assign enc_ready = ENCODER_MODE.video_encoder_core_on && ENCODER_MODE.nonstd_timing &&
                     ENCODER_MODE.timing_master && ENCODER_MODE.hd_mode &&
                     ENCODER_MODE.progressive;

  // window-0-only with field inversion cleared is the supported set-up
  assign cfg_ok = enc_ready && clk_sel_ext && (VIDEO_WINDOW_MODE == 2'b01) &&
                  !OVERLAY_FIELD_INVERT;

  assign h_act = (st_ff.hcnt >= `HDT_H_ACTIVE_START) &&
                 (st_ff.hcnt < `HDT_H_ACTIVE_START + `HDT_H_ACTIVE_LENGTH);
  assign v_act = (st_ff.vcnt >= `HDT_V_ACTIVE_START) &&
                 (st_ff.vcnt < `HDT_V_ACTIVE_START + `HDT_V_ACTIVE_LENGTH);

  assign win_on = {OVERLAY_WINDOW_ON, VIDEO_WINDOW_MODE[1] & 1'b0, VIDEO_WINDOW_MODE[0]};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_win
      logic [10:0] x0;
      logic [9:0]  y0;
      assign x0 = WIN_CFG[gi].x_offset + `HDT_BASE_X;
      assign y0 = WIN_CFG[gi].y_offset + `HDT_BASE_Y;
      assign hit_now[gi] = win_on[gi] &&
                           (st_ff.hcnt >= x0) && (st_ff.hcnt < x0 + WIN_CFG[gi].width) &&
                           (st_ff.vcnt >= y0) && (st_ff.vcnt < y0 + WIN_CFG[gi].height);
    end
  endgenerate

  assign fifo_pop = pix_en && TIMING_ENABLE && h_act && v_act &&
                    (DIGITAL_OUTPUT_CONTROL == `HDT_DIGOUT_ON);

  always_comb begin
    nxt_st        = st_ff;
    nxt_st.ext_s1 = EXTERNAL_PIXEL_CLOCK_IN;
    nxt_st.ext_s2 = st_ff.ext_s1;
    nxt_st.ext_d  = st_ff.ext_s2;
    nxt_st.cfg_ok = cfg_ok;
    nxt_st.pclk   = pat_level;
    if (!TIMING_ENABLE || !enc_clk_on) begin
      nxt_st.hcnt  = '0;
      nxt_st.vcnt  = '0;
      nxt_st.hsync = 1'b0;
      nxt_st.vsync = 1'b0;
      nxt_st.oe    = 1'b0;
      nxt_st.hit   = '0;
      nxt_st.video = '0;
    end else if (pix_en) begin
      // syncs, output enable, window hits and video advance together on the pixel rising edge
      if (st_ff.hcnt == `HDT_LINE_PERIOD_M1) begin
        nxt_st.hcnt = '0;
        nxt_st.vcnt = (st_ff.vcnt == `HDT_FRAME_PERIOD_M1) ? 10'd0 : st_ff.vcnt + 10'd1;
      end else begin
        nxt_st.hcnt = st_ff.hcnt + 11'd1;
      end
      // zero sync delay: syncs begin at count 0
      nxt_st.hsync = SYNC_OUTPUTS_ON && (st_ff.hcnt < `HDT_HSYNC_WIDTH);
      nxt_st.vsync = SYNC_OUTPUTS_ON && (st_ff.vcnt == 10'd0);
      nxt_st.oe    = h_act && v_act;
      nxt_st.hit   = hit_now;
      nxt_st.video = fifo_pop ? (fifo_valid ? fifo_data : 16'h0000) : 16'h0000;
      if (fifo_pop && !fifo_valid) begin
        nxt_st.underrun = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // progressive: field id held low, pin disabled; output-enable pin on
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      FIELD_ID              <= 1'b0;
      FIELD_ID_PIN_ENABLE   <= 1'b0;
      DISPLAY_OE_PIN_ENABLE <= 1'b0;
    end else begin
      FIELD_ID              <= 1'b0;
      FIELD_ID_PIN_ENABLE   <= 1'b0;
      DISPLAY_OE_PIN_ENABLE <= 1'b1;
    end
  end

  assign PIXEL_CLOCK_OUT = st_ff.pclk;
  assign HSYNC           = st_ff.hsync;
  assign VSYNC           = st_ff.vsync;
  assign DISPLAY_OE      = st_ff.oe;
  assign WIN_HIT         = st_ff.hit;
  assign VIDEO_OUT       = st_ff.video;
  assign UNDERRUN        = st_ff.underrun;
  assign CONFIG_OK       = st_ff.cfg_ok;

  property p_hcnt_wrap;
    @(posedge CLK) disable iff (!RST_N)
      (pix_en && TIMING_ENABLE && enc_clk_on && st_ff.hcnt == `HDT_LINE_PERIOD_M1)
        |=> st_ff.hcnt == 11'd0;
  endproperty
  a_hcnt_wrap: assert property (p_hcnt_wrap) else $error("line did not wrap at 1650");

  property p_hsync_width;
    @(posedge CLK) disable iff (!RST_N)
      (pix_en && TIMING_ENABLE && enc_clk_on && SYNC_OUTPUTS_ON)
        |=> (HSYNC == ($past(st_ff.hcnt) < 11'd80));
  endproperty
  a_hsync_width: assert property (p_hsync_width) else $error("hsync width not 80");

  property p_oe_start;
    @(posedge CLK) disable iff (!RST_N)
      (pix_en && TIMING_ENABLE && enc_clk_on && st_ff.hcnt == 11'd300 && st_ff.vcnt == 10'd26)
        |=> DISPLAY_OE;
  endproperty
  a_oe_start: assert property (p_oe_start) else $error("active did not start at 300/26");

  property p_no_oe_vblank;
    @(posedge CLK) disable iff (!RST_N)
      (st_ff.vcnt < 10'd26 && st_ff.hcnt != 11'd0) |-> !st_ff.oe;
  endproperty
  a_no_oe_vblank: assert property (p_no_oe_vblank) else $error("active in vertical blank");

  property p_right_blank;
    @(posedge CLK) disable iff (!RST_N)
      (pix_en && TIMING_ENABLE && enc_clk_on && st_ff.hcnt >= 11'd1580) |=> !DISPLAY_OE;
  endproperty
  a_right_blank: assert property (p_right_blank) else $error("active in right blanking");

  property p_vcnt_wrap;
    @(posedge CLK) disable iff (!RST_N)
      (pix_en && TIMING_ENABLE && enc_clk_on && st_ff.hcnt == 11'd1649 && st_ff.vcnt == 10'd749)
        |=> st_ff.vcnt == 10'd0;
  endproperty
  a_vcnt_wrap: assert property (p_vcnt_wrap) else $error("frame did not wrap at 750");

  sequence s_ext_rise;
    st_ff.ext_s2 && !st_ff.ext_d && enc_clk_on;
  endsequence
  property p_clk_copy;
    @(posedge CLK) disable iff (!RST_N)
      s_ext_rise |=> pix_en ##1 PIXEL_CLOCK_OUT;
  endproperty
  a_clk_copy: assert property (p_clk_copy) else $error("pixel clock not a copy of input");

  property p_field_off;
    @(posedge CLK) disable iff (!RST_N)
      $rose(RST_N) ##1 1'b1 |-> !FIELD_ID_PIN_ENABLE && DISPLAY_OE_PIN_ENABLE;
  endproperty
  a_field_off: assert property (p_field_off) else $error("pin enables wrong");

  property p_win1_off;
    @(posedge CLK) disable iff (!RST_N) !WIN_HIT[1];
  endproperty
  a_win1_off: assert property (p_win1_off) else $error("video window 1 active");

  property p_digout;
    @(posedge CLK) disable iff (!RST_N)
      (DIGITAL_OUTPUT_CONTROL != 8'h01) |-> !fifo_pop;
  endproperty
  a_digout: assert property (p_digout) else $error("data popped with output off");

  property p_refuse_clock;
    @(posedge CLK) disable iff (!RST_N)
      !clk_sel_ext |=> st_ff.hcnt == 11'd0 && st_ff.vcnt == 10'd0 &&
                       !HSYNC && !VSYNC && !DISPLAY_OE;
  endproperty
  a_refuse_clock: assert property (p_refuse_clock) else $error("timing ran on wrong clock");

  property p_vsync_line;
    @(posedge CLK) disable iff (!RST_N)
      (pix_en && TIMING_ENABLE && enc_clk_on && SYNC_OUTPUTS_ON)
        |=> (VSYNC == ($past(st_ff.vcnt) == 10'd0));
  endproperty
  a_vsync_line: assert property (p_vsync_line) else $error("vsync not on frame line 0");

  // between pixel ticks the syncs, output enable and video output may not move
  sequence s_no_tick;
    !pix_en && TIMING_ENABLE && enc_clk_on;
  endsequence
  property p_hold_between_ticks;
    @(posedge CLK) disable iff (!RST_N)
      s_no_tick |=> $stable(HSYNC) && $stable(VSYNC) && $stable(DISPLAY_OE) &&
                    $stable(VIDEO_OUT);
  endproperty
  a_hold_between_ticks: assert property (p_hold_between_ticks) else $error("output moved off tick");

  property p_underrun_sticky;
    @(posedge CLK) disable iff (!RST_N)
      UNDERRUN |=> UNDERRUN;
  endproperty
  a_underrun_sticky: assert property (p_underrun_sticky) else $error("underrun flag lost");

  property p_pclk_pulse;
    @(posedge CLK) disable iff (!RST_N)
      PIXEL_CLOCK_OUT |=> !PIXEL_CLOCK_OUT;
  endproperty
  a_pclk_pulse: assert property (p_pclk_pulse) else $error("pixel clock pulse too long");
endmodule // hdt_timing
`default_nettype wire

//--- sim/hdt_encoder_model.sv
// encoder model: measures each line seen on the sync and pixel-clock pins
`timescale 1ns/1ps
`default_nettype none
module hdt_encoder_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        pclk,
  input  wire logic        hsync,
  input  wire logic        vsync,
  input  wire logic        oe,
  input  wire logic        win,
  output logic             rec_valid,
  output logic [10:0]      len,
  output logic [10:0]      hsw,
  output logic [10:0]      vst,
  output logic [10:0]      oet,
  output logic [10:0]      wst,
  output logic [10:0]      wln,
  output logic [3:0]       gap
);
  logic        hs_q, win_q, seen;
  logic [10:0] idx, c_hs, c_vs, c_oe, c_ws, c_wl;
  logic [3:0]  gcnt;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {hs_q, win_q, seen, rec_valid, gcnt, gap} <= '0;
      {idx, c_hs, c_vs, c_oe, c_ws, c_wl} <= '0;
      {len, hsw, vst, oet, wst, wln} <= '0;
    end else begin
      rec_valid <= 1'b0;
      gcnt <= gcnt + 4'h1;
      // everything is sampled at the pixel pulse only, as the encoder would
      if (pclk) begin
        gap <= gcnt;
        gcnt <= 4'h1;
        hs_q <= hsync;
        win_q <= win;
        if (hsync && !hs_q) begin
          // a partial first line is dropped; records start at a sync rise
          rec_valid <= seen;
          seen <= 1'b1;
          {len, hsw, vst, oet, wst, wln} <= {idx, c_hs, c_vs, c_oe, c_ws, c_wl};
          idx <= 11'd1;
          c_hs <= 11'd1;
          c_vs <= 11'(vsync);
          c_oe <= 11'(oe);
          c_wl <= 11'(win);
          c_ws <= '0;
        end else begin
          idx <= idx + 11'd1;
          c_hs <= c_hs + 11'(hsync);
          c_vs <= c_vs + 11'(vsync);
          c_oe <= c_oe + 11'(oe);
          c_wl <= c_wl + 11'(win);
          if (win && !win_q) begin
            c_ws <= idx;
          end
        end
      end
    end
  end
endmodule // hdt_encoder_model
`default_nettype wire

//--- sim/hdt_timing_test.sv
// self-checking bench for the 720-line display timing generator
`timescale 1ns/1ps
`default_nettype none
`include "hdt_map.svh"
module hdt_timing_test;
  import hdt_pkg::*;
  typedef struct packed {
    logic [10:0] len, hsw, vst, oet, wst, wln;
  } hdt_rec_s;
  localparam int LINK_NS = 64;
  localparam int CLK_NS  = 8;
  logic        clk, rst_n, ext_clk, t_en, sync_on, fld_inv, pix_valid;
  logic [7:0]  clk_ctl, dig_ctl;
  hdt_mode_s   mode;
  logic [1:0]  vid_md, osd_on;
  hdt_win_s    win_cfg [4];
  hdt_pix_t    pix_data, vout;
  logic        pix_ready, pclk, hs, vs, oe, fid, fid_en, oe_en, underrun, cfg_ok, rec_valid;
  logic [3:0]  win_hit, gap;
  hdt_rec_s    rec, e, x;
  hdt_rec_s    exp_q [$];
  int          fails, cmp_count, cycles, npulse, n0, acc;
  logic [31:0] rng;

  initial begin
    clk = 1'b0;
    forever #(CLK_NS / 2) clk = ~clk;
  end
  initial begin
    ext_clk = 1'b0;
    #3;
    forever #(LINK_NS / 2) ext_clk = ~ext_clk;
  end

  hdt_timing #(.FIFO_DEPTH(4)) dut (
    .CLK(clk), .RST_N(rst_n), .EXTERNAL_PIXEL_CLOCK_IN(ext_clk), .TIMING_ENABLE(t_en),
    .VIDEO_SUBSYSTEM_CLOCK_CONTROL(clk_ctl), .DIGITAL_OUTPUT_CONTROL(dig_ctl),
    .SYNC_OUTPUTS_ON(sync_on), .ENCODER_MODE(mode), .VIDEO_WINDOW_MODE(vid_md),
    .OVERLAY_WINDOW_ON(osd_on), .OVERLAY_FIELD_INVERT(fld_inv), .WIN_CFG(win_cfg),
    .PIX_DATA(pix_data), .PIX_VALID(pix_valid), .PIX_READY(pix_ready),
    .PIXEL_CLOCK_OUT(pclk), .HSYNC(hs), .VSYNC(vs), .DISPLAY_OE(oe), .FIELD_ID(fid),
    .FIELD_ID_PIN_ENABLE(fid_en), .DISPLAY_OE_PIN_ENABLE(oe_en), .VIDEO_OUT(vout),
    .WIN_HIT(win_hit), .UNDERRUN(underrun), .CONFIG_OK(cfg_ok));

  hdt_encoder_model enc (
    .clk(clk), .rst_n(rst_n), .pclk(pclk), .hsync(hs), .vsync(vs), .oe(oe),
    .win(win_hit[2]), .rec_valid(rec_valid), .len(rec.len), .hsw(rec.hsw),
    .vst(rec.vst), .oet(rec.oet), .wst(rec.wst), .wln(rec.wln), .gap(gap));

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    cmp_count++;
    if (seen !== want) begin
      fails++;
      $display("[ERR] %0t mismatch seen %h want %h", $time, seen, want);
    end
  endtask

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  task automatic print_verdict();
    if (fails == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // pulse count and hang guard; six lines need about 80k cycles
  always @(posedge clk) begin
    cycles++;
    if (pclk === 1'b1) begin
      npulse++;
    end
    if (cycles == 95000) begin
      fails++;
      $display("[ERR] %0t timeout", $time);
      print_verdict();
    end
  end

  always @(posedge clk) begin
    if (rst_n && rec_valid === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      check(16'(rec.len), 16'(e.len));
      check(16'(rec.hsw), 16'(e.hsw));
      check(16'(rec.vst), 16'(e.vst));
      check(16'(rec.oet), 16'(e.oet));
      check(16'(rec.wst), 16'(e.wst));
      check(16'(rec.wln), 16'(e.wln));
    end
  end

  initial begin
    rng = 32'hd35d7bbc;
    rst_n = 1'b0;
    t_en = 1'b1;
    clk_ctl = 8'h0b;
    dig_ctl = `HDT_DIGOUT_ON;
    sync_on = 1'b1;
    mode = '1;
    vid_md = 2'b01;
    osd_on = 2'b01;
    fld_inv = 1'b0;
    pix_data = '0;
    pix_valid = 1'b0;
    foreach (win_cfg[i]) begin
      win_cfg[i] = '{`HDT_WIN_X_OFFSET, `HDT_WIN_Y_OFFSET, 11'd1280, 10'd720};
    end
    // a one-line overlay window placed early enough to be seen within the run
    win_cfg[2] = '{11'd20, 10'd0, 11'd1 + 11'(xs() % 16), 10'd1};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check(16'(fid_en), 16'h0);
    check(16'(oe_en), 16'h1);
    check(16'(fid), 16'h0);
    n0 = npulse;
    repeat (40) @(posedge clk);
    check(16'(npulse - n0), 16'h0);
    t_en <= 1'b0;
    clk_ctl <= `HDT_VSS_CLK_EXT;
    for (int b = 0; b < 5; b++) begin
      mode <= 5'h1f ^ (5'h01 << b);
      repeat (4) @(posedge clk);
      check(16'(cfg_ok), 16'h0);
    end
    mode <= '1;
    fld_inv <= 1'b1;
    repeat (4) @(posedge clk);
    check(16'(cfg_ok), 16'h0);
    fld_inv <= 1'b0;
    vid_md <= 2'b11;
    repeat (4) @(posedge clk);
    check(16'(cfg_ok), 16'h0);
    vid_md <= 2'b01;
    repeat (4) @(posedge clk);
    check(16'(cfg_ok), 16'h1);
    // with timing disabled nothing pops, so the fifo must refuse the fifth word
    acc = 0;
    pix_valid <= 1'b1;
    pix_data <= 16'(xs());
    repeat (8) begin
      @(posedge clk);
      if (pix_ready === 1'b1) begin
        acc++;
        pix_data <= 16'(xs());
      end
    end
    pix_valid <= 1'b0;
    check(16'(acc), 16'd4);
    mode <= 5'h0f;
    t_en <= 1'b1;
    // a pulse already in flight when the clock is gated still reaches the pin
    repeat (4) @(posedge clk);
    @(negedge clk);
    n0 = npulse;
    repeat (40) @(posedge clk);
    check(16'(npulse - n0), 16'h0);
    for (int l = 0; l < 6; l++) begin
      x.len = 11'(`HDT_LINE_PERIOD_M1 + 11'd1);
      x.hsw = `HDT_HSYNC_WIDTH;
      x.vst = (l == 0) ? x.len : 11'd0;
      x.oet = '0;
      x.wst = (l == 5) ? `HDT_BASE_X + win_cfg[2].x_offset : 11'd0;
      x.wln = (l == 5) ? win_cfg[2].width : 11'd0;
      exp_q.push_back(x);
    end
    mode <= '1;
    wait (exp_q.size() == 0);
    @(negedge clk);
    check(16'(gap), 16'(LINK_NS / CLK_NS));
    check(16'(underrun), 16'h0);
    check(16'(vout), 16'h0);
    check(16'(pix_ready), 16'h0);
    print_verdict();
  end
endmodule // hdt_timing_test
`default_nettype wire
